// >>> design/mps_pkg.sv
// Package for the microprogram sequencer: store sizes, field layout of the
// microinstruction, sequencer control codes and reset values.
// Assumes a single processor clock with one micro cycle per microinstruction.
package mps_pkg;

  // Store geometry
  localparam int ROM_WORDS = 2048;
  localparam int WCS_WORDS = 256;
  localparam int UWORD_W = 64;
  localparam int UADDR_W = 12;
  localparam int MAP_ENTRIES = 2048;
  localparam int MAP_ADDR_W = 11;
  localparam int STACK_DEPTH = 8;

  // Opcode slice of the machine instruction
  localparam int OPC_LO = 6;
  localparam int OPC_HI = 15;

  // Microinstruction layout: [63:60] sequencer control, [59:56] condition select,
  // [55:44] branch address, [43:0] datapath control
  localparam int SEQ_LO = 60;
  localparam int SEQ_HI = 63;
  localparam int CSEL_LO = 56;
  localparam int CSEL_HI = 59;
  localparam int BADDR_LO = 44;
  localparam int BADDR_HI = 55;
  localparam int CTL_W = 44;
  // Datapath control sub-fields
  localparam int ALU_LO = 0;
  localparam int ALU_HI = 7;
  localparam int SRC_LO = 8;
  localparam int SRC_HI = 11;
  localparam int DST_LO = 12;
  localparam int DST_HI = 15;
  localparam int DIRECT_LO = 16;
  localparam int DIRECT_HI = 43;
  localparam int BUS_SRCS = 16;
  localparam int BUS_DSTS = 16;
  localparam logic [3:0] BUS_NONE = 4'h0;

  // Sequencer control codes
  localparam logic [3:0] SEQ_CONT = 4'h0;
  localparam logic [3:0] SEQ_JUMP = 4'h1;
  localparam logic [3:0] SEQ_CJMP = 4'h2;
  localparam logic [3:0] SEQ_CALL = 4'h3;
  localparam logic [3:0] SEQ_CCALL = 4'h4;
  localparam logic [3:0] SEQ_RET = 4'h5;
  localparam logic [3:0] SEQ_CRET = 4'h6;
  localparam logic [3:0] SEQ_MAP = 4'h7;
  localparam logic [3:0] SEQ_CMAP = 4'h8;

  // Reset values
  localparam logic [11:0] RESET_UADDR = 12'h000;
  localparam logic [63:0] UNOP = 64'h0000_0000_0000_0000;
  // Writable store sits directly above the ROM, at 12'h800 to 12'h8ff
  localparam logic [11:0] WCS_BASE = 12'h800;

endpackage

// >>> design/mps_ustore.sv
// Control store: 2K word read-only array plus optional 256 word writable part.
// Assumes contents are loaded by a plain constant table; readout is asynchronous.
`timescale 1ns/1ps
module mps_ustore #(
  parameter int ADDR_W = mps_pkg::UADDR_W,
  parameter int WORD_W = mps_pkg::UWORD_W,
  parameter bit HAS_WCS = 1'b1
) (
  // Clock
  input wire logic clock,
  // Read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_word,
  // Writable store load port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_word
);

  logic [WORD_W-1:0] rom [mps_pkg::ROM_WORDS];
  logic [WORD_W-1:0] wcs [mps_pkg::WCS_WORDS];
  logic wcs_hit;

  // Microprogram image; filled with no-operation words by default
  initial begin
    for (int i = 0; i < mps_pkg::ROM_WORDS; i++) begin
      rom[i] = mps_pkg::UNOP;
    end
  end

  // Writable store updated by software load path
  always_ff @(posedge clock) begin
    if (HAS_WCS && wr_en) begin
      wcs[wr_addr] <= wr_word;
    end
  end

  // Addresses 12'h800 to 12'h8ff select the writable store when fitted; other upper addresses read the ROM
  assign wcs_hit = HAS_WCS && (rd_addr[ADDR_W-1] == 1'b1) && (rd_addr[ADDR_W-2:8] == '0);
  assign rd_word = wcs_hit ? wcs[rd_addr[7:0]] : rom[rd_addr[10:0]];

endmodule // mps_ustore

// >>> design/mps_sequencer.sv
// Microprogram sequencer top: entry-point map, next-address logic with return
// stack, control store and pipeline register driving datapath control lines.
// Assumes the datapath supplies status from the previous micro cycle on this clock.
`timescale 1ns/1ps
module mps_sequencer #(
  parameter int DEPTH = mps_pkg::STACK_DEPTH,
  parameter bit HAS_WCS = 1'b1,
  parameter int NCOND = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Machine instruction from datapath
  input wire logic [15:0] instr_word,
  input wire logic [1:0] paging_control_reg_ring,
  // Status from previous micro cycle
  input wire logic [NCOND-1:0] status_flags,
  // Writable store load port
  input wire logic wcs_wr_en,
  input wire logic [7:0] wcs_wr_addr,
  input wire logic [63:0] wcs_wr_word,
  // Datapath control outputs
  output logic [7:0] arithmetic_logic_unit_op,
  output logic [27:0] direct_ctl,
  output logic [15:0] bus_src_en,
  output logic [15:0] bus_dst_en,
  output logic [11:0] uaddr,
  output logic map_taken,
  output logic stack_overflow,
  output logic stack_underflow
);

  typedef struct packed {
    logic [11:0] upc;
    logic [43:0] pipe;
    logic [DEPTH-1:0][11:0] stack;
    logic [$clog2(DEPTH+1)-1:0] sp;
    logic map_hit;
    logic ovf;
    logic unf;
  } mps_state_s;

  mps_state_s st_reg;
  mps_state_s st_next;

  // Entry-point map: index bit 10 is the inverted top ring bit, set for rings 0 and 1 (the privileged table)
  logic [11:0] map_rom [mps_pkg::MAP_ENTRIES];
  logic [10:0] map_index;
  logic [11:0] map_out;
  logic [63:0] uword;
  logic [3:0] seq_field;
  logic [3:0] cond_sel;
  logic [11:0] branch_addr;
  logic cond_true;
  logic [11:0] next_addr;
  logic push;
  logic pop;

  // Map table image; defaults to the reset address for every opcode
  initial begin
    for (int i = 0; i < mps_pkg::MAP_ENTRIES; i++) begin
      map_rom[i] = mps_pkg::RESET_UADDR;
    end
  end

  // Control store read at the current sequencer address
  mps_ustore #(
    .ADDR_W(mps_pkg::UADDR_W),
    .WORD_W(mps_pkg::UWORD_W),
    .HAS_WCS(HAS_WCS)
  ) u_store (
    .clock(clock),
    .rd_addr(st_reg.upc),
    .rd_word(uword),
    .wr_en(wcs_wr_en),
    .wr_addr(wcs_wr_addr),
    .wr_word(wcs_wr_word)
  );

  // Map lookup from opcode bits and ring privilege
  assign map_index = {~paging_control_reg_ring[1], instr_word[mps_pkg::OPC_HI:mps_pkg::OPC_LO]};
  assign map_out = map_rom[map_index];

  // Sequencer fields taken straight from store output
  assign seq_field = uword[mps_pkg::SEQ_HI:mps_pkg::SEQ_LO];
  assign cond_sel = uword[mps_pkg::CSEL_HI:mps_pkg::CSEL_LO];
  assign branch_addr = uword[mps_pkg::BADDR_HI:mps_pkg::BADDR_LO];
  assign cond_true = status_flags[cond_sel];

  // Next-address selection
  always_comb begin
    next_addr = st_reg.upc + 12'h001;
    push = 1'b0;
    pop = 1'b0;
    unique case (seq_field)
      mps_pkg::SEQ_CONT: next_addr = st_reg.upc + 12'h001;
      mps_pkg::SEQ_JUMP: next_addr = branch_addr;
      mps_pkg::SEQ_CJMP: next_addr = cond_true ? branch_addr : st_reg.upc + 12'h001;
      mps_pkg::SEQ_CALL: begin
        next_addr = branch_addr;
        push = 1'b1;
      end
      mps_pkg::SEQ_CCALL: begin
        next_addr = cond_true ? branch_addr : st_reg.upc + 12'h001;
        push = cond_true;
      end
      mps_pkg::SEQ_RET: pop = 1'b1;
      mps_pkg::SEQ_CRET: pop = cond_true;
      mps_pkg::SEQ_MAP: next_addr = map_out;
      mps_pkg::SEQ_CMAP: next_addr = cond_true ? map_out : st_reg.upc + 12'h001;
      default: next_addr = st_reg.upc + 12'h001;
    endcase
    if (pop) begin
      next_addr = (st_reg.sp == '0) ? mps_pkg::RESET_UADDR : st_reg.stack[st_reg.sp - 1'b1];
    end
  end

  // State update: sequencer address and pipeline load together
  always_comb begin
    st_next = st_reg;
    st_next.upc = next_addr;
    st_next.pipe = uword[mps_pkg::CTL_W-1:0];
    st_next.map_hit = (seq_field == mps_pkg::SEQ_MAP) || (seq_field == mps_pkg::SEQ_CMAP && cond_true);
    if (push) begin
      if (st_reg.sp == DEPTH[$bits(st_reg.sp)-1:0]) begin
        st_next.ovf = 1'b1;
      end else begin
        st_next.stack[st_reg.sp] = st_reg.upc + 12'h001;
        st_next.sp = st_reg.sp + 1'b1;
      end
    end
    if (pop) begin
      if (st_reg.sp == '0) begin
        st_next.unf = 1'b1;
      end else begin
        st_next.sp = st_reg.sp - 1'b1;
      end
    end
    if (sys_rst) begin
      st_next = '0;
      st_next.upc = mps_pkg::RESET_UADDR;
      st_next.pipe = mps_pkg::UNOP[mps_pkg::CTL_W-1:0];
    end
  end

  // Single edge registers sequencer and pipeline
  always_ff @(posedge clock) begin
    st_reg <= st_next;
  end

  // Pipeline outputs: direct lines and decoded bus enables
  assign arithmetic_logic_unit_op = st_reg.pipe[mps_pkg::ALU_HI:mps_pkg::ALU_LO];
  assign direct_ctl = st_reg.pipe[mps_pkg::DIRECT_HI:mps_pkg::DIRECT_LO];

  // Decode guarantees at most one source on the internal word bus; code zero enables none
  genvar g;
  generate
    for (g = 1; g < mps_pkg::BUS_SRCS; g++) begin : g_dec
      assign bus_src_en[g] = (st_reg.pipe[mps_pkg::SRC_HI:mps_pkg::SRC_LO] == 4'(g));
      assign bus_dst_en[g] = (st_reg.pipe[mps_pkg::DST_HI:mps_pkg::DST_LO] == 4'(g));
    end
  endgenerate
  assign bus_src_en[0] = 1'b0; // Code zero means no source
  assign bus_dst_en[0] = 1'b0;

  // Status outputs
  assign uaddr = st_reg.upc;
  assign map_taken = st_reg.map_hit;
  assign stack_overflow = st_reg.ovf;
  assign stack_underflow = st_reg.unf;

endmodule // mps_sequencer

// >>> verif/mps_sequencer_monitor.sv
// Checker for the microprogram sequencer top: reset state, decode, sequencing and stack flags.
// Assumes one clock, a synchronous active-high reset and the default ROM image of continue words.
`timescale 1ns/1ps
module mps_sequencer_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Observed outputs
  input wire logic [7:0] arithmetic_logic_unit_op,
  input wire logic [27:0] direct_ctl,
  input wire logic [15:0] bus_src_en,
  input wire logic [15:0] bus_dst_en,
  input wire logic [11:0] uaddr,
  input wire logic map_taken,
  input wire logic stack_overflow,
  input wire logic stack_underflow
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // A ROM word that is not the last one of the ROM
  sequence s_rom_word;
    !uaddr[11] && uaddr != 12'h7ff;
  endsequence
  // A ROM word followed by its pipeline cycle
  sequence s_rom_fetch;
    !uaddr[11] ##1 1'b1;
  endsequence
  a_reset_clears_state:
    assert property (disable iff (1'b0) sys_rst |=> uaddr == 12'h000 && bus_src_en == 16'h0000 && !stack_overflow
      && !stack_underflow && !map_taken) else $error("state not cleared by reset");
  a_src_one_hot:
    assert property ($onehot0(bus_src_en)) else $error("more than one bus source enabled");
  a_dst_one_hot:
    assert property ($onehot0(bus_dst_en)) else $error("more than one bus destination enabled");
  a_cont_step_up:
    assert property (s_rom_word |=> uaddr == $past(uaddr) + 12'h001) else $error("continue did not step address");
  a_rom_ctl_quiet:
    assert property (s_rom_fetch |-> arithmetic_logic_unit_op == 8'h00 && direct_ctl == 28'h0000000)
      else $error("no-op word drove control lines");
  a_overflow_sticky:
    assert property (stack_overflow |=> stack_overflow) else $error("overflow flag dropped");
  a_underflow_sticky:
    assert property (stack_underflow |=> stack_underflow) else $error("underflow flag dropped");
  a_underflow_to_zero:
    assert property ($rose(stack_underflow) |-> uaddr == 12'h000) else $error("empty pop not sent to zero");
endmodule // mps_sequencer_monitor

// >>> verif/mps_datapath_model.sv
// Datapath partner: registers status for the sequencer, supplies the instruction, counts transfers.
// Assumes status is produced one micro cycle before the sequencer uses it.
`timescale 1ns/1ps
module mps_datapath_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control lines from the pipeline register
  input wire logic [15:0] bus_src_en,
  input wire logic [15:0] bus_dst_en,
  // Scenario setting
  input wire logic [15:0] cond_set,
  // Toward the sequencer and the bench
  output logic [15:0] instr_word,
  output logic [15:0] status_flags,
  output logic [7:0] xfer_count
);
  // Status of the previous micro cycle; one word moves per enabled source and destination
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_flags <= 16'h0000;
      xfer_count <= 8'h00;
    end else begin
      status_flags <= cond_set;
      if (bus_src_en != 16'h0000 && bus_dst_en != 16'h0000) xfer_count <= xfer_count + 8'h01;
    end
  end
  // Prefetched instruction held on the word bus
  assign instr_word = 16'h1c40;
endmodule // mps_datapath_model

// >>> verif/mps_sequencer_tb_top.sv
// Testbench for the microprogram sequencer: loads a writable-store program and traces it.
// Assumes default ROM and map images (continue words, map entries of zero).
`timescale 1ns/1ps
module mps_sequencer_tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] paging_control_reg_ring = 2'h2;
  logic wcs_wr_en = 1'b0;
  logic [7:0] wcs_wr_addr = 8'h00;
  logic [63:0] wcs_wr_word = 64'h0;
  logic [15:0] cond_set = 16'h0004;
  logic [15:0] instr_word, status_flags, bus_src_en, bus_dst_en;
  logic [7:0] arithmetic_logic_unit_op, xfer_count;
  logic [27:0] direct_ctl;
  logic [11:0] uaddr;
  logic map_taken, stack_overflow, stack_underflow;
  int n_fail = 0;
  int check_count = 0;
  // Free-running processor clock
  always #2.5 clock = ~clock;
  mps_sequencer DUT (.clock, .sys_rst, .instr_word, .paging_control_reg_ring, .status_flags, .wcs_wr_en,
    .wcs_wr_addr, .wcs_wr_word, .arithmetic_logic_unit_op, .direct_ctl, .bus_src_en, .bus_dst_en, .uaddr,
    .map_taken, .stack_overflow, .stack_underflow);
  mps_datapath_model u_dp (.clock, .sys_rst, .bus_src_en, .bus_dst_en, .cond_set, .instr_word, .status_flags,
    .xfer_count);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [63:0] mk(logic [3:0] s, logic [3:0] c, logic [11:0] b, logic [43:0] d);
    return {s, c, b, d};
  endfunction
  // Sample outputs mid-cycle
  task automatic step;
    @(negedge clock);
  endtask
  // One writable-store word per write pulse
  task automatic wr(input logic [7:0] a, input logic [63:0] w);
    @(posedge clock);
    wcs_wr_en <= 1'b1;
    wcs_wr_addr <= a;
    wcs_wr_word <= w;
    @(posedge clock);
    wcs_wr_en <= 1'b0;
  endtask
  task automatic wait_addr(input logic [11:0] a);
    for (int i = 0; i < 3000 && uaddr !== a; i++) step();
    if (uaddr !== a) begin
      n_fail++;
      $display("MISMATCH t=%0t address %h never reached", $time, a);
      results();
    end
  endtask
  task automatic t_reset_start;
    step();
    chk(uaddr, 64'h0);
    chk(arithmetic_logic_unit_op, 64'h0);
    repeat (5) step();
    chk(uaddr, 64'h5);
  endtask
  task automatic t_load;
    wr(8'h00, mk(mps_pkg::SEQ_CONT, 4'h0, 12'h000, {28'h1234567, 4'h5, 4'h3, 8'ha5}));
    wr(8'h01, mk(mps_pkg::SEQ_CALL, 4'h0, 12'h810, 44'h0));
    wr(8'h10, mk(mps_pkg::SEQ_RET, 4'h0, 12'h000, 44'h0));
    wr(8'h02, mk(mps_pkg::SEQ_CJMP, 4'h2, 12'h820, 44'h0));
    wr(8'h20, mk(mps_pkg::SEQ_CJMP, 4'h3, 12'h830, 44'h0));
    wr(8'h21, mk(mps_pkg::SEQ_MAP, 4'h0, 12'h000, 44'h0));
    wait_addr(12'h800);
  endtask
  task automatic t_fields;
    step();
    chk(uaddr, 64'h801);
    chk(arithmetic_logic_unit_op, 64'ha5);
    chk(bus_src_en, 64'h0008);
    chk(bus_dst_en, 64'h0020);
    chk(direct_ctl, 64'h1234567);
  endtask
  task automatic t_call_return;
    step();
    chk(uaddr, 64'h810);
    chk(direct_ctl, 64'h0);
    step();
    chk(uaddr, 64'h802);
  endtask
  task automatic t_cond_branch;
    step();
    chk(uaddr, 64'h820);
    step();
    chk(uaddr, 64'h821);
  endtask
  task automatic t_map;
    step();
    chk(uaddr, 64'h0);
    chk(map_taken, 64'h1);
    chk(xfer_count, 64'h1);
  endtask
  task automatic t_underflow_reset;
    wr(8'h21, mk(mps_pkg::SEQ_RET, 4'h0, 12'h000, 44'h0));
    wait_addr(12'h821);
    step();
    chk(uaddr, 64'h0);
    chk(stack_underflow, 64'h1);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    step();
    chk({stack_underflow, stack_overflow, uaddr}, 64'h0);
  endtask
  // Self-calling word fills the eight-deep stack, the ninth push must flag
  task automatic t_overflow;
    wr(8'h21, mk(mps_pkg::SEQ_JUMP, 4'h0, 12'h830, 44'h0));
    wr(8'h30, mk(mps_pkg::SEQ_CALL, 4'h0, 12'h830, 44'h0));
    wait_addr(12'h830);
    repeat (8) step();
    chk(stack_overflow, 64'h0);
    step();
    chk(stack_overflow, 64'h1);
    chk(uaddr, 64'h830);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset_start();
    t_load();
    t_fields();
    t_call_return();
    t_cond_branch();
    t_map();
    t_underflow_reset();
    t_overflow();
    results();
  end
endmodule // mps_sequencer_tb_top
bind mps_sequencer mps_sequencer_monitor u_mon (.clock, .sys_rst, .arithmetic_logic_unit_op, .direct_ctl,
  .bus_src_en, .bus_dst_en, .uaddr, .map_taken, .stack_overflow, .stack_underflow);
